// [rtl/csr_cfg.svh]
// addresses, field positions and reset values of the core register map
`ifndef CSR_CFG_SVH
`define CSR_CFG_SVH

// ----------------------------------------------------------------
// register addresses (bank 1 adds 8'h80)
// ----------------------------------------------------------------
`define CSR_A_INDIRECT   8'h00
`define CSR_A_TIMER      8'h01
`define CSR_A_PC_LOW     8'h02
`define CSR_A_STATUS     8'h03
`define CSR_A_POINTER    8'h04
`define CSR_A_PORT_A     8'h05
`define CSR_A_PORT_B     8'h06
`define CSR_A_CONV_CTRL  8'h08
`define CSR_A_RESULT     8'h09
`define CSR_A_PC_HIGH    8'h0a
`define CSR_A_INT_CTRL   8'h0b
`define CSR_A_PERIPH_FLG 8'h0c
`define CSR_A_OPTION     8'h81
`define CSR_A_DIR_A      8'h85
`define CSR_A_DIR_B      8'h86
`define CSR_A_POWER      8'h87
`define CSR_A_PIN_CFG    8'h88
`define CSR_A_GP_BASE    8'h20

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CSR_ST_TIMEOUT   4
`define CSR_ST_PWRDOWN   3
`define CSR_ST_BANK      5
`define CSR_PF_CONV_DONE 6
`define CSR_CC_GP_BIT    5

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CSR_RV_STATUS    8'h18
`define CSR_RV_OPTION    8'hff
`define CSR_RV_DIR_A     5'h1f
`define CSR_RV_DIR_B     8'hff
`define CSR_RV_ZERO8     8'h00
`define CSR_RV_ZERO5     5'h00

`endif

// [rtl/csr_pkg.sv]
// types shared by the core register map
`default_nettype none
package csr_pkg;

    // one core access to data memory
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } csr_req_t;

    // cause of a non power-up reset
    typedef struct packed {
        logic req;      // one-cycle reset request (pin or watchdog)
        logic timeout;  // watchdog timed out
        logic pwrdown;  // woke or reset from sleep
    } csr_rst_cause_t;

endpackage : csr_pkg

`default_nettype wire

// [rtl/csr_gp_ram.sv]
// general purpose data memory behind the register map
`timescale 1ns/100ps
`default_nettype none

module csr_gp_ram #(
    parameter int DEPTH = 48
) (
    // clock
    input  wire logic                     clk,
    // write port
    input  wire logic                     we,
    input  wire logic [$clog2(DEPTH)-1:0] waddr,
    input  wire logic [7:0]               wdata,
    // read port
    input  wire logic [$clog2(DEPTH)-1:0] raddr,
    output logic      [7:0]               rdata
);

    logic [7:0] mem [DEPTH];

    // storage only, contents undefined at power-up
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    assign rdata = mem[raddr];

endmodule : csr_gp_ram

`default_nettype wire

// [rtl/csr_regmap.sv]
// core special-function register map with banked mirroring
//
// Operation
// - unimplemented locations and bits read as zero
// - shared core registers mirrored in both banks
// - high buffer loads upper counter on update
// - power control reads zero without brown-out
// - converter bit 5 storage or zero per variant
// - status 0001_1000 power-on, 000q_quuu otherwise
// - u bits hold, q bits follow reset cause
`timescale 1ns/100ps
`default_nettype none
`include "csr_cfg.svh"

module csr_regmap import csr_pkg::*; #(
    parameter bit HAS_BOR     = 1'b1,
    parameter bit CONV_GP_BIT = 1'b1,
    parameter int GP_DEPTH    = 48
) (
    // clock and power-on / brown-out reset
    input  wire logic           clk,
    input  wire logic           rst_n,
    // other resets: pin or watchdog
    input  wire csr_rst_cause_t other_rst,
    // core data-memory access
    input  wire csr_req_t       req,
    output logic [7:0]          rdata_q,
    // program counter control
    input  wire logic           pc_inc,
    input  wire logic           pc_jump,
    input  wire logic [7:0]     pc_jump_low,
    output logic [12:0]         pc_q,
    // alu flags
    input  wire logic           alu_flags_we,
    input  wire logic [2:0]     alu_flags,
    // hardware event flags
    input  wire logic [2:0]     int_flag_set,
    input  wire logic           conv_done_set,
    input  wire logic           conv_result_we,
    input  wire logic [7:0]     conv_result,
    // pins and controls
    input  wire logic [4:0]     port_a_pins,
    input  wire logic [7:0]     port_b_pins,
    output logic [4:0]          port_a_latch_q,
    output logic [7:0]          port_b_latch_q,
    output logic [4:0]          port_a_direction_q,
    output logic [7:0]          port_b_direction_q,
    output logic [7:0]          option_settings_q,
    output logic [7:0]          interrupt_control_q,
    output logic [7:0]          converter_control_q,
    output logic [1:0]          converter_pin_config_q
);

    localparam int GW = $clog2(GP_DEPTH);

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [7:0] timer_count_value_q;
    logic [7:0] core_status_q;
    logic [7:0] indirect_pointer_q;
    logic [4:0] counter_high_buffer_q;
    logic [7:0] peripheral_flags_one_q;
    logic [1:0] power_control_q;
    logic [7:0] conversion_result_q;
    logic [7:0] gp_rdata;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    wire        is_ind   = (req.addr[6:0] == 7'(`CSR_A_INDIRECT));
    wire [7:0]  ea       = is_ind ? indirect_pointer_q : req.addr;
    wire [6:0]  lo       = ea[6:0];
    wire        b1       = ea[7];
    // mirrored core registers ignore the bank bit
    wire        h_ind    = (lo == 7'(`CSR_A_INDIRECT));
    wire        h_pcl    = (lo == 7'(`CSR_A_PC_LOW));
    wire        h_stat   = (lo == 7'(`CSR_A_STATUS));
    wire        h_ptr    = (lo == 7'(`CSR_A_POINTER));
    wire        h_res    = (lo == 7'(`CSR_A_RESULT));
    wire        h_pch    = (lo == 7'(`CSR_A_PC_HIGH));
    wire        h_int    = (lo == 7'(`CSR_A_INT_CTRL));
    // banked registers
    wire        h_tmr    = (ea == `CSR_A_TIMER);
    wire        h_pa     = (ea == `CSR_A_PORT_A);
    wire        h_pb     = (ea == `CSR_A_PORT_B);
    wire        h_cc     = (ea == `CSR_A_CONV_CTRL);
    wire        h_pf     = (ea == `CSR_A_PERIPH_FLG);
    wire        h_opt    = (ea == `CSR_A_OPTION);
    wire        h_da     = (ea == `CSR_A_DIR_A);
    wire        h_db     = (ea == `CSR_A_DIR_B);
    wire        h_pwr    = (ea == `CSR_A_POWER);
    wire        h_pcf    = (ea == `CSR_A_PIN_CFG);
    wire [7:0]  gp_off   = ea - `CSR_A_GP_BASE;
    wire        h_gp     = !b1 && (ea >= `CSR_A_GP_BASE)
                           && (gp_off < 8'(GP_DEPTH));
    wire        wr       = req.wr;

    // converter control mask, bit 5 only where it is storage
    wire [7:0]  cc_mask  = CONV_GP_BIT ? 8'hff : 8'hdf;

    // ----------------------------------------------------------------
    // read multiplexer, anything unmatched reads zero
    // ----------------------------------------------------------------
    wire [7:0] rd_mux =
        h_ind  ? 8'h00 :
        h_tmr  ? timer_count_value_q :
        h_pcl  ? pc_q[7:0] :
        h_stat ? core_status_q :
        h_ptr  ? indirect_pointer_q :
        h_pa   ? {3'h0, port_a_pins} :
        h_pb   ? port_b_pins :
        h_cc   ? (converter_control_q & cc_mask) :
        h_res  ? conversion_result_q :
        h_pch  ? {3'h0, counter_high_buffer_q} :
        h_int  ? interrupt_control_q :
        h_pf   ? peripheral_flags_one_q :
        h_opt  ? option_settings_q :
        h_da   ? {3'h0, port_a_direction_q} :
        h_db   ? port_b_direction_q :
        h_pwr  ? {6'h00, power_control_q & {2{HAS_BOR}}} :
        h_pcf  ? {6'h00, converter_pin_config_q} :
        h_gp   ? gp_rdata :
                 8'h00;

    // ----------------------------------------------------------------
    // general purpose memory
    // ----------------------------------------------------------------
    csr_gp_ram #(
        .DEPTH (GP_DEPTH)
    ) u_ram (
        .clk   (clk),
        .we    (wr && h_gp),
        .waddr (gp_off[GW-1:0]),
        .wdata (req.wdata),
        .raddr (gp_off[GW-1:0]),
        .rdata (gp_rdata)
    );

    // ----------------------------------------------------------------
    // read data register
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n || other_rst.req) begin
            rdata_q <= `CSR_RV_ZERO8;
        end else if (req.rd) begin
            rdata_q <= rd_mux;
        end
    end

    // ----------------------------------------------------------------
    // program counter and its high buffer
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n || other_rst.req) begin
            pc_q                  <= 13'h0000;
            counter_high_buffer_q <= `CSR_RV_ZERO5;
        end else begin
            if (wr && h_pch) begin
                counter_high_buffer_q <= req.wdata[4:0];
            end
            if (wr && h_pcl) begin
                pc_q <= {counter_high_buffer_q, req.wdata};
            end else if (pc_jump) begin
                pc_q <= {counter_high_buffer_q, pc_jump_low};
            end else if (pc_inc) begin
                pc_q <= pc_q + 13'h0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // core status: power-up, other reset, core and software writes
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            core_status_q <= `CSR_RV_STATUS;
        end else if (other_rst.req) begin
            core_status_q <= {3'h0, ~other_rst.timeout,
                              ~other_rst.pwrdown,
                              core_status_q[2:0]};
        end else if (wr && h_stat) begin
            // upper bank bits stored as written; software keeps them clear
            core_status_q <= {req.wdata[7:5],
                              core_status_q[`CSR_ST_TIMEOUT],
                              core_status_q[`CSR_ST_PWRDOWN],
                              req.wdata[2:0]};
        end else if (alu_flags_we) begin
            core_status_q[2:0] <= alu_flags;
        end
    end

    // ----------------------------------------------------------------
    // registers that hold their value across other resets, except port A latch bits 3:0
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            timer_count_value_q <= `CSR_RV_ZERO8;
            indirect_pointer_q  <= `CSR_RV_ZERO8;
            port_a_latch_q      <= `CSR_RV_ZERO5;
            port_b_latch_q      <= `CSR_RV_ZERO8;
            conversion_result_q <= `CSR_RV_ZERO8;
            power_control_q     <= 2'h0;
        end else begin
            if (other_rst.req) begin
                port_a_latch_q[3:0] <= 4'h0;
            end else if (wr && h_pa) begin
                port_a_latch_q <= req.wdata[4:0];
            end
            if (!other_rst.req) begin
                if (wr && h_tmr) begin
                    timer_count_value_q <= req.wdata;
                end
                if (wr && h_ptr) begin
                    indirect_pointer_q <= req.wdata;
                end
                if (wr && h_pb) begin
                    port_b_latch_q <= req.wdata;
                end
                if (wr && h_pwr && HAS_BOR) begin
                    power_control_q <= req.wdata[1:0];
                end
                if (conv_result_we) begin
                    conversion_result_q <= conv_result;
                end else if (wr && h_res) begin
                    conversion_result_q <= req.wdata;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // control registers reset by every reset class
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n || other_rst.req) begin
            option_settings_q      <= `CSR_RV_OPTION;
            port_a_direction_q     <= `CSR_RV_DIR_A;
            port_b_direction_q     <= `CSR_RV_DIR_B;
            converter_control_q    <= `CSR_RV_ZERO8;
            converter_pin_config_q <= 2'h0;
        end else begin
            if (wr && h_opt) begin
                option_settings_q <= req.wdata;
            end
            if (wr && h_da) begin
                port_a_direction_q <= req.wdata[4:0];
            end
            if (wr && h_db) begin
                port_b_direction_q <= req.wdata;
            end
            if (wr && h_cc) begin
                converter_control_q <= req.wdata & cc_mask;
            end
            if (wr && h_pcf) begin
                converter_pin_config_q <= req.wdata[1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // interrupt control: enables clear, flag bit 0 holds on other reset
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_int
            wire hw_set = (gi < 3) ? int_flag_set[gi % 3] : 1'b0;
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    interrupt_control_q[gi] <= 1'b0;
                end else if (other_rst.req) begin
                    if (gi != 0) begin
                        interrupt_control_q[gi] <= 1'b0;
                    end
                end else if (hw_set) begin
                    interrupt_control_q[gi] <= 1'b1;  // set beats clear
                end else if (wr && h_int) begin
                    interrupt_control_q[gi] <= req.wdata[gi];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // peripheral flags: only the conversion-done bit exists
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n || other_rst.req) begin
            peripheral_flags_one_q <= `CSR_RV_ZERO8;
        end else if (conv_done_set) begin
            peripheral_flags_one_q[`CSR_PF_CONV_DONE] <= 1'b1;
        end else if (wr && h_pf) begin
            peripheral_flags_one_q[`CSR_PF_CONV_DONE] <=
                req.wdata[`CSR_PF_CONV_DONE];
        end
    end

endmodule : csr_regmap

`default_nettype wire

// [bench/csr_regmap_assertions.sv]
// port assertions for the core register map
`timescale 1ns/100ps
`default_nettype none
module csr_regmap_chk import csr_pkg::*; #(
    parameter bit HAS_BOR     = 1'b1,
    parameter bit CONV_GP_BIT = 1'b1
) (
    // clock and resets
    input wire logic           clk,
    input wire logic           rst_n,
    input wire csr_rst_cause_t other_rst,
    // access and counter
    input wire csr_req_t       req,
    input wire logic [7:0]     rdata_q,
    input wire logic           pc_inc,
    input wire logic           pc_jump,
    input wire logic [7:0]     pc_jump_low,
    input wire logic [12:0]    pc_q,
    // register outputs
    input wire logic [4:0]     port_a_latch_q,
    input wire logic [7:0]     port_b_latch_q,
    input wire logic [7:0]     option_settings_q,
    input wire logic [7:0]     interrupt_control_q
);
    // ----------
    // properties
    // ----------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // read taken with no other reset
    wire logic rd_ok = req.rd && !other_rst.req;

    AST_POR_VALUES: assert property (disable iff (1'b0)
        !rst_n |=> option_settings_q == 8'hff && pc_q == 13'h0000)
        else $error("power-on values wrong");
    AST_OTHER_INT: assert property (
        other_rst.req |=> interrupt_control_q[7:1] == 7'h00
        && interrupt_control_q[0] == $past(interrupt_control_q[0]))
        else $error("interrupt control wrong after other reset");
    AST_OTHER_KEEP: assert property (
        other_rst.req |=> port_a_latch_q[3:0] == 4'h0 && pc_q == 13'h0000
        && port_b_latch_q == $past(port_b_latch_q)
        && option_settings_q == 8'hff)
        else $error("other reset values wrong");
    AST_UNIMPL_ZERO: assert property (
        rd_ok && req.addr inside {8'h07, 8'h0d, 8'h0f} |=> rdata_q == 8'h00)
        else $error("unimplemented read not zero");
    AST_MIRROR: assert property (
        rd_ok && req.addr inside {8'h0b, 8'h8b}
        |=> rdata_q == $past(interrupt_control_q))
        else $error("mirrored read differs");
    AST_JUMP_LOW: assert property (
        pc_jump && !pc_inc && !req.wr && !other_rst.req
        |=> pc_q[7:0] == $past(pc_jump_low))
        else $error("jump low byte wrong");
    AST_HIGH_HIDDEN: assert property (
        req.wr && req.addr inside {8'h0a, 8'h8a} && !pc_inc && !pc_jump
        && !other_rst.req |=> $stable(pc_q))
        else $error("high buffer write moved counter");
    AST_POWER_ZERO: assert property (
        rd_ok && !HAS_BOR && req.addr == 8'h87 |=> rdata_q == 8'h00)
        else $error("power control not zero");
    AST_CONV_BIT: assert property (
        rd_ok && !CONV_GP_BIT && req.addr == 8'h08 |=> !rdata_q[5])
        else $error("converter bit five not zero");

    // main scenarios
    cover property (other_rst.req);
    cover property (pc_jump ##2 pc_inc);
    cover property (req.wr && req.addr == 8'h00);
endmodule : csr_regmap_chk

bind csr_regmap csr_regmap_chk #(
    .HAS_BOR    (HAS_BOR),
    .CONV_GP_BIT(CONV_GP_BIT)
) chk_u (.clk, .rst_n, .other_rst, .req, .rdata_q, .pc_inc, .pc_jump,
    .pc_jump_low, .pc_q, .port_a_latch_q, .port_b_latch_q,
    .option_settings_q, .interrupt_control_q);
`default_nettype wire

// [bench/tb_csr_regmap.sv]
// self-checking bench for the core register map
`timescale 1ns/100ps
`default_nettype none
module tb_csr_regmap import csr_pkg::*;;
    // ----------------
    // stimulus and dut
    // ----------------
    logic           clk            = 1'b0;
    logic           rst_n          = 1'b0;
    csr_rst_cause_t other_rst      = '0;
    csr_req_t       req            = '0;
    logic           pc_inc         = 1'b0;
    logic           pc_jump        = 1'b0;
    logic [7:0]     pc_jump_low    = 8'h34;
    logic           alu_flags_we   = 1'b0;
    logic [2:0]     alu_flags      = 3'h5;
    logic [2:0]     int_flag_set   = 3'h0;
    logic           conv_done_set  = 1'b0;
    logic           conv_result_we = 1'b0;
    logic [7:0]     conv_result    = 8'hc3;
    logic [4:0]     port_a_pins    = 5'h0a;
    logic [7:0]     port_b_pins    = 8'h3c;
    logic [7:0]     rdata_q;
    logic [7:0]     rdata_v;
    logic [12:0]    pc_q;
    logic [4:0]     port_a_latch_q, port_a_direction_q;
    logic [7:0]     port_b_latch_q, port_b_direction_q;
    logic [7:0]     option_settings_q, interrupt_control_q;
    logic [7:0]     converter_control_q;
    logic [1:0]     converter_pin_config_q;
    int             errors         = 0;
    int             checks_done    = 0;
    int             cyc            = 0;
    // address and expected read after reset
    logic [15:0] rt[13] = '{16'h0318, 16'h8318, 16'h81ff, 16'h851f,
        16'h86ff, 16'h8800, 16'h0200, 16'h0a00, 16'h0b00, 16'h8700,
        16'h0700, 16'h050a, 16'h063c};
    // write address and data, then read address and value
    logic [31:0] wt[18] = '{32'h87ff8700, 32'h07ff0700, 32'h85ff851f,
        32'h88ff8803, 32'h08200800, 32'h8ba50ba5, 32'h04218421,
        32'h893c093c, 32'h8a150a15, 32'h86a586a5, 32'h03208338,
        32'h03000318, 32'h04208420, 32'h00552055, 32'h042f842f,
        32'h80662f66, 32'h04200055, 32'h04008000};
    logic [15:0] ht[4] = '{16'h09c3, 16'h0c40, 16'h8ba7, 16'h831d};
    logic [15:0] ot[3] = '{16'h0a00, 16'h8400, 16'h89c3};

    csr_regmap #(.HAS_BOR(1'b0), .CONV_GP_BIT(1'b0)) dut_u (.clk, .rst_n,
        .other_rst, .req, .rdata_q, .pc_inc, .pc_jump, .pc_jump_low, .pc_q,
        .alu_flags_we, .alu_flags, .int_flag_set, .conv_done_set,
        .conv_result_we, .conv_result, .port_a_pins, .port_b_pins,
        .port_a_latch_q, .port_b_latch_q, .port_a_direction_q,
        .port_b_direction_q, .option_settings_q, .interrupt_control_q,
        .converter_control_q, .converter_pin_config_q);
    // second variant: power control and converter bit five stored
    csr_regmap #(.HAS_BOR(1'b1), .CONV_GP_BIT(1'b1)) dut_v (.clk, .rst_n,
        .other_rst, .req, .rdata_q(rdata_v), .pc_inc, .pc_jump,
        .pc_jump_low, .pc_q(), .alu_flags_we, .alu_flags, .int_flag_set,
        .conv_done_set, .conv_result_we, .conv_result, .port_a_pins,
        .port_b_pins, .port_a_latch_q(), .port_b_latch_q(),
        .port_a_direction_q(), .port_b_direction_q(),
        .option_settings_q(), .interrupt_control_q(),
        .converter_control_q(), .converter_pin_config_q());

    // clock and hang limit
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 1000) begin
            errors++;
            report_and_stop();
        end
    end

    // ----------
    // bus tasks
    // ----------
    task automatic chk(input string nm, input logic [12:0] seen,
                       input logic [12:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // one access: address in upper byte, data in lower byte
    task automatic acc(input logic rd, input logic [15:0] ad);
        @(posedge clk);
        req <= '{rd: rd, wr: !rd, addr: ad[15:8], wdata: ad[7:0]};
        @(posedge clk);
        req <= '0;
        #1;
    endtask : acc
    task automatic rd(input logic [15:0] ae);
        acc(1'b1, ae);
        chk($sformatf("read %h", ae[15:8]), 13'(rdata_q), 13'(ae[7:0]));
    endtask : rd
    task automatic wrd(input logic [31:0] w);
        acc(1'b0, w[31:16]);
        rd(w[15:0]);
    endtask : wrd
    // other reset with given cause, then status read
    task automatic orst(input logic [2:0] c, input logic [7:0] st);
        @(posedge clk) other_rst <= c;
        @(posedge clk) other_rst <= '0;
        rd({8'h03, st});
    endtask : orst
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : report_and_stop

    // ----------
    // tests
    // ----------
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rt[i]) rd(rt[i]);
        $display("test reset values done");
        foreach (wt[i]) wrd(wt[i]);
        rd(16'h8700);
        chk("power v", 13'(rdata_v), 13'h003);
        rd(16'h0800);
        chk("conv ctrl v", 13'(rdata_v), 13'h020);
        chk("conv ctrl", 13'(converter_control_q), 13'h000);
        chk("pin cfg", 13'(converter_pin_config_q), 13'h003);
        chk("dir b", 13'(port_b_direction_q), 13'h0a5);
        $display("test access table done");
        @(posedge clk);
        {conv_result_we, conv_done_set, alu_flags_we} <= 3'h7;
        int_flag_set <= 3'h7;
        @(posedge clk);
        {conv_result_we, conv_done_set, alu_flags_we} <= 3'h0;
        int_flag_set <= 3'h0;
        foreach (ht[i]) rd(ht[i]);
        chk("counter", pc_q, 13'h0000);
        @(posedge clk) pc_jump <= 1'b1;
        @(posedge clk) pc_jump <= 1'b0;
        #1 chk("counter", pc_q, 13'h1534);
        @(posedge clk) pc_inc <= 1'b1;
        @(posedge clk) pc_inc <= 1'b0;
        #1 chk("counter", pc_q, 13'h1535);
        acc(1'b0, 16'h0277);
        chk("counter", pc_q, 13'h1577);
        $display("test hardware and counter done");
        acc(1'b0, 16'h051f);
        acc(1'b0, 16'h065a);
        acc(1'b0, 16'h8100);
        orst(3'b110, 8'h0d);
        chk("int ctrl", 13'(interrupt_control_q), 13'h001);
        chk("latch a", 13'(port_a_latch_q), 13'h010);
        chk("latch b", 13'(port_b_latch_q), 13'h05a);
        chk("option", 13'(option_settings_q), 13'h0ff);
        chk("counter", pc_q, 13'h0000);
        chk("dir a", 13'(port_a_direction_q), 13'h01f);
        chk("dir b", 13'(port_b_direction_q), 13'h0ff);
        chk("pin cfg", 13'(converter_pin_config_q), 13'h000);
        foreach (ot[i]) rd(ot[i]);
        orst(3'b101, 8'h15);
        $display("test other reset done");
        report_and_stop();
    end
endmodule : tb_csr_regmap
`default_nettype wire
